// File: rtl/tbs_defs.svh
// offsets, field positions, reset values and counts of the serializer
`ifndef TBS_DEFS_SVH
`define TBS_DEFS_SVH

// register offsets (byte addresses)
`define TBS_ADR_CTRL 8'h00
`define TBS_ADR_STATUS 8'h04

// control register fields
`define TBS_CTRL_LOCK_LSB 0
`define TBS_CTRL_LOCK_MSB 7
`define TBS_LOCK_WORDS_RST 8'h10

// status register fields
`define TBS_ST_LOCKED 0
`define TBS_ST_PATTERN 1
`define TBS_ST_DRIVING 2
`define TBS_ST_IGNORE 3
`define TBS_ST_AWAKE 4
`define TBS_ST_WORD_LSB 16
`define TBS_ST_WORD_MSB 25

// frame layout and timing counts
`define TBS_IGNORE_WORDS 3'h5
`define TBS_BITS_PER_FRAME 13'h000c
`define TBS_LAST_BIT 4'hb
`define TBS_SYNC_PATTERN 12'h03f
`define TBS_START_BIT 1'b1
`define TBS_STOP_BIT 1'b0
`define TBS_PERIOD_MAX 12'hfff

`endif

// File: rtl/tbs_pkg.sv
// types used only inside the serializer; the bench does not use them
package tbs_pkg;

  // all asynchronous pins, synchronised as one vector
  typedef struct packed {
    logic word_clk;
    logic edge_sel;
    logic req_a;
    logic req_b;
    logic drive_en;
    logic sleep_n;
    logic [9:0] word;
  } tbs_pins_type;

  // lock tracking of the word clock
  typedef enum logic [1:0] {
    LK_OFF,
    LK_ACQ,
    LK_RUN
  } tbs_lock_type;

endpackage

// File: rtl/tbs_serializer.sv
// ten-bit framing serializer with wishbone control and status
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "tbs_defs.svh"

// How it works
// - output tri-stated, logic idle until locked
// - once locked send data or sync pattern
// - pattern is six ones, six zeros per word
// - pattern stops when both requests low
// - edge select high rising, low falling
// - request high five words ignores data
// - start bit one, stop bit zero added
// - twelve bits sent per word clock period
// - data only with drive, awake, no requests
// - drive enable low tri-states both legs
// - drive enable high resumes previous state
// - either request alone starts the pattern
// - sleep low stops lock, tri-states output
// - after sleep both ends relock first
module tbs_serializer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic word_clock_in_i,
  input wire logic strobe_edge_select_i,
  input wire logic [9:0] parallel_word_in_i,
  input wire logic pattern_request_a_i,
  input wire logic pattern_request_b_i,
  input wire logic output_drive_enable_i,
  input wire logic sleep_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic serial_p_o,
  output logic serial_n_o,
  output logic serial_oe_n_o
);

  tbs_pkg::tbs_pins_type pin_raw;
  tbs_pkg::tbs_pins_type pin_meta_ff;
  tbs_pkg::tbs_pins_type pins;
  tbs_pkg::tbs_lock_type lock_ff;
  tbs_pkg::tbs_lock_type nxt_lock;
  logic clk_dly_ff;
  logic rise;
  logic fall;
  logic strobe;
  logic [11:0] per_cnt_ff;
  logic [11:0] per_ff;
  logic stall;
  logic [7:0] lock_cnt_ff;
  logic [7:0] lock_words_ff;
  logic locked;
  logic any_req;
  logic [2:0] req_cnt_ff;
  logic ignore;
  logic [9:0] word_ff;
  logic [11:0] frame_ff;
  logic frame_valid_ff;
  logic pat_ff;
  logic [3:0] bit_cnt_ff;
  logic [12:0] acc_ff;
  logic [12:0] nxt_acc;
  logic drive;
  logic serial_p_ff;
  logic serial_n_ff;
  logic serial_oe_n_ff;
  logic wb_req;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] rd_data;

  // every pin but the wishbone bus is foreign to clk_sys_i; all but rst_i pass two flops
  assign pin_raw.word_clk = word_clock_in_i;
  assign pin_raw.edge_sel = strobe_edge_select_i;
  assign pin_raw.req_a = pattern_request_a_i;
  assign pin_raw.req_b = pattern_request_b_i;
  assign pin_raw.drive_en = output_drive_enable_i;
  assign pin_raw.sleep_n = sleep_n_i;
  assign pin_raw.word = parallel_word_in_i;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_ff <= '0;
      pins <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pins <= pin_meta_ff;
    end
  end

  // edge detection looks only at the second stage
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_dly_ff <= 1'b0;
    end else begin
      clk_dly_ff <= pins.word_clk;
    end
  end

  assign rise = pins.word_clk & ~clk_dly_ff;
  assign fall = ~pins.word_clk & clk_dly_ff;
  assign strobe = pins.edge_sel ? rise : fall;

  // word period in system cycles; a stopped clock saturates it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      per_cnt_ff <= '0;
      per_ff <= '0;
    end else if (strobe) begin
      per_cnt_ff <= '0;
      per_ff <= stall ? per_cnt_ff : per_cnt_ff + 12'h001;
    end else if (!stall) begin
      per_cnt_ff <= per_cnt_ff + 12'h001;
    end
  end

  assign stall = per_cnt_ff == `TBS_PERIOD_MAX;

  // lock emulation: a run of steady strobes stands in for the pll
  always_comb begin
    nxt_lock = lock_ff;
    unique case (lock_ff)
      tbs_pkg::LK_OFF: begin
        if (pins.sleep_n) begin
          nxt_lock = tbs_pkg::LK_ACQ;
        end
      end
      tbs_pkg::LK_ACQ: begin
        if (!pins.sleep_n) begin
          nxt_lock = tbs_pkg::LK_OFF;
        end else if (strobe && !stall &&
                     lock_cnt_ff == lock_words_ff) begin
          nxt_lock = tbs_pkg::LK_RUN;
        end
      end
      tbs_pkg::LK_RUN: begin
        if (!pins.sleep_n) begin
          nxt_lock = tbs_pkg::LK_OFF;
        end else if (stall) begin
          nxt_lock = tbs_pkg::LK_ACQ;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= tbs_pkg::LK_OFF;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_cnt_ff <= '0;
    end else if (lock_ff != tbs_pkg::LK_ACQ || stall) begin
      lock_cnt_ff <= '0;
    end else if (strobe && lock_cnt_ff != lock_words_ff) begin
      lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end
  end

  assign locked = lock_ff == tbs_pkg::LK_RUN;

  // either request alone asks for the pattern
  assign any_req = pins.req_a | pins.req_b;

  // count strobes while a request stands, stop at five
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_cnt_ff <= '0;
    end else if (!any_req) begin
      req_cnt_ff <= '0;
    end else if (strobe && req_cnt_ff != `TBS_IGNORE_WORDS) begin
      req_cnt_ff <= req_cnt_ff + 3'h1;
    end
  end

  assign ignore = req_cnt_ff == `TBS_IGNORE_WORDS;

  // last captured word, visible to software
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      word_ff <= '0;
    end else if (strobe && locked && !ignore) begin
      word_ff <= pins.word;
    end
  end

  // bit pacing: add twelve per cycle, step a bit per period
  // worth, so twelve bits span one measured word period
  assign nxt_acc = acc_ff + `TBS_BITS_PER_FRAME;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      frame_ff <= '0;
      frame_valid_ff <= 1'b0;
      pat_ff <= 1'b0;
      bit_cnt_ff <= '0;
      acc_ff <= '0;
    end else if (!locked) begin
      frame_valid_ff <= 1'b0;
      pat_ff <= 1'b0;
      bit_cnt_ff <= '0;
      acc_ff <= '0;
    end else if (strobe) begin
      frame_valid_ff <= 1'b1;
      bit_cnt_ff <= '0;
      acc_ff <= '0;
      pat_ff <= any_req;
      if (any_req) begin
        frame_ff <= `TBS_SYNC_PATTERN;
      end else begin
        // sent lsb first: start, bit 0 .. bit 9, stop
        frame_ff <= {`TBS_STOP_BIT, pins.word, `TBS_START_BIT};
      end
    end else if (frame_valid_ff && bit_cnt_ff != `TBS_LAST_BIT) begin
      if (nxt_acc >= {1'b0, per_ff}) begin
        acc_ff <= nxt_acc - {1'b0, per_ff};
        frame_ff <= {1'b0, frame_ff[11:1]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else begin
        acc_ff <= nxt_acc;
      end
    end
  end

  // pattern ends at the first strobe after both requests drop
  // (the next frame then carries data again)
  assign drive = locked & pins.sleep_n & pins.drive_en &
                 frame_valid_ff;

  // drive enable only masks the pins; framing runs on, so the
  // previous state is back the moment it returns high
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      serial_oe_n_ff <= 1'b1;
      serial_p_ff <= 1'b0;
      serial_n_ff <= 1'b0;
    end else begin
      serial_oe_n_ff <= ~drive;
      serial_p_ff <= drive & frame_ff[0];
      serial_n_ff <= drive & ~frame_ff[0];
    end
  end

  assign serial_p_o = serial_p_ff;
  assign serial_n_o = serial_n_ff;
  assign serial_oe_n_o = serial_oe_n_ff;

  // wishbone slave: ack one cycle after the request is seen
  assign wb_req = wb_cyc_i & wb_stb_i;

  always_comb begin
    rd_data = '0;
    if (wb_adr_i == `TBS_ADR_CTRL) begin
      rd_data[`TBS_CTRL_LOCK_MSB:`TBS_CTRL_LOCK_LSB] = lock_words_ff;
    end else if (wb_adr_i == `TBS_ADR_STATUS) begin
      rd_data[`TBS_ST_LOCKED] = locked;
      rd_data[`TBS_ST_PATTERN] = pat_ff;
      rd_data[`TBS_ST_DRIVING] = ~serial_oe_n_ff;
      rd_data[`TBS_ST_IGNORE] = ignore;
      rd_data[`TBS_ST_AWAKE] = pins.sleep_n;
      rd_data[`TBS_ST_WORD_MSB:`TBS_ST_WORD_LSB] = word_ff;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
      // read data stands only beside ack, zero in every other cycle
      if (wb_req && !ack_ff && !wb_we_i) begin
        dat_ff <= rd_data;
      end else begin
        dat_ff <= '0;
      end
    end
  end

  // the write lands on the edge where the master samples ack
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_words_ff <= `TBS_LOCK_WORDS_RST;
    end else if (wb_req && ack_ff && wb_we_i &&
                 wb_adr_i == `TBS_ADR_CTRL && wb_sel_i[0]) begin
      lock_words_ff <= wb_dat_i[`TBS_CTRL_LOCK_MSB:`TBS_CTRL_LOCK_LSB];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule // tbs_serializer

// File: tb/tbs_serializer_chk.sv
// port assertions for the serializer
`timescale 1ns/1ps
module tbs_serializer_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sleep_n_i,
  input wire logic output_drive_enable_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_p_o,
  input wire logic serial_n_o,
  input wire logic serial_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_quiet;
    serial_oe_n_o [*3];
  endsequence
  a_boot_quiet: assert property ($fell(rst_i) |-> s_quiet)
    else $error("serial pair driven right after reset");
  a_hiz_legs: assert property (serial_oe_n_o |-> !serial_p_o && !serial_n_o)
    else $error("legs not idle while released");
  a_legs_diff: assert property (!serial_oe_n_o |-> serial_p_o != serial_n_o)
    else $error("legs not complementary");
  // seven cycles covers the two-stage pin sync plus the output register
  a_sleep_hiz: assert property (!sleep_n_i [*7] |-> serial_oe_n_o)
    else $error("pair driven while asleep");
  a_drive_off: assert property (!output_drive_enable_i [*7] |-> serial_oe_n_o)
    else $error("pair driven while drive disabled");
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("bus access not answered next cycle");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_rd: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i != 8'h00 && wb_adr_i != 8'h04 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // tbs_serializer_chk
bind tbs_serializer tbs_serializer_chk u_tbs_serializer_chk (.clk_sys_i,
  .rst_i, .sleep_n_i, .output_drive_enable_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .serial_p_o, .serial_n_o, .serial_oe_n_o);

// File: tb/tbs_rx_model.sv
// receiver model: recovers frames and reports lock active low
`timescale 1ns/1ps
module tbs_rx_model #(
  parameter int BIT_CYC = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic serial_p_i,
  input wire logic serial_n_i,
  input wire logic serial_oe_n_i,
  output logic lock_n_o,
  output logic [11:0] frame_o,
  output logic frame_v_o
);
  logic bit_w;
  logic prev_ff;
  logic [11:0] sh_ff;
  int cnt_ff;
  assign bit_w = serial_p_i & ~serial_n_i;
  // samples the second cycle of each bit, start bit found on a rise
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 0;
      lock_n_o <= 1'b1;
      frame_v_o <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      frame_v_o <= 1'b0;
      prev_ff <= bit_w;
      if (serial_oe_n_i) begin
        cnt_ff <= 0;
        lock_n_o <= 1'b1;
      end else if (cnt_ff == 0) begin
        if (bit_w && !prev_ff) cnt_ff <= 1;
      end else if (cnt_ff == 12 * BIT_CYC - 1) begin
        cnt_ff <= 0;
        frame_o <= {bit_w, sh_ff[10:0]};
        frame_v_o <= 1'b1;
        lock_n_o <= !(sh_ff[0] && !bit_w);
      end else begin
        cnt_ff <= cnt_ff + 1;
        if (cnt_ff % BIT_CYC == BIT_CYC - 1) sh_ff[cnt_ff / BIT_CYC] <= bit_w;
      end
    end
  end
endmodule // tbs_rx_model

// File: tb/test_tbs_serializer.sv
// self-checking bench for the serializer
`timescale 1ns/1ps
module test_tbs_serializer;
  logic clk = 0, rst = 1, wclk = 0, es = 1, ra = 0, de = 1, sl = 1;
  logic cyc = 0, stb = 0, we = 0, chk = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, dato;
  logic [9:0] wa = 10'h0, wb_w = 10'h0, word = 10'h0, cap;
  logic lock_n, p, n, oe_n, ack, frame_v;
  logic [11:0] frame;
  int n_errors = 0, num_checks = 0, ph = 0, n_frames = 0;
  tbs_serializer u_tbs_serializer (.clk_sys_i(clk), .rst_i(rst),
    .word_clock_in_i(wclk), .strobe_edge_select_i(es),
    .parallel_word_in_i(word), .pattern_request_a_i(ra),
    .pattern_request_b_i(lock_n),
    .output_drive_enable_i(de), .sleep_n_i(sl), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .serial_p_o(p),
    .serial_n_o(n), .serial_oe_n_o(oe_n));
  tbs_rx_model u_tbs_rx_model (.clk_sys_i(clk), .rst_i(rst),
    .serial_p_i(p), .serial_n_i(n), .serial_oe_n_i(oe_n), .lock_n_o(lock_n),
    .frame_o(frame), .frame_v_o(frame_v));
  always #5 clk = ~clk;
  // 24-cycle word clock: wa stands at rising, wb_w at falling edge
  always @(posedge clk) begin
    ph <= (ph == 23) ? 0 : ph + 1;
    if (ph == 0) wclk <= 1'b1;
    if (ph == 12) wclk <= 1'b0;
    if (ph == 6) word <= wb_w;
    if (ph == 18) word <= wa;
  end
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(negedge clk) begin
    if (frame_v && chk) begin
      n_frames++;
      check("frame", (ra | lock_n) ? 12'h03f : {1'b0, es ? wa : wb_w, 1'b1},
        frame);
    end
  end
  task automatic wbx(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    // ack and read data are taken at the same rising edge
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    rd = dato;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk);
  endtask
  task automatic per(int k);
    repeat (24 * k) @(posedge clk);
  endtask
  task automatic st(logic [4:0] f, logic [9:0] w);
    wbx(1'b0, 8'h04, 32'h0);
    check("status", {6'h0, w, 11'h0, f}, rd);
  endtask
  task automatic summarize;
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
  initial begin
    void'($urandom(32'h478a62db));
    repeat (8) @(posedge clk);
    rst <= 0;
    per(2);
    check("oe_n", 1, oe_n);
    wbx(1'b1, 8'h00, 32'h2);
    wbx(1'b1, 8'h10, 32'hffff_ffff);
    wbx(1'b1, 8'h04, 32'hffff_ffff);
    wbx(1'b0, 8'h00, 32'h0);
    check("ctrl", 32'h2, rd);
    wbx(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h0, rd);
    per(12);
    for (int i = 0; i < 4; i++) begin
      chk <= 0;
      es <= i[0];
      wa <= 10'($urandom);
      wb_w <= 10'($urandom);
      per(6);
      chk <= 1;
      per(4);
      st(5'h15, es ? wa : wb_w);
    end
    cap = wa;
    chk <= 0;
    ra <= 1;
    per(2); // frames already in flight still carry data
    chk <= 1;
    per(6);
    wa <= ~wa; // ignored while the request stands
    per(4);
    st(5'h1f, cap);
    chk <= 0;
    ra <= 0;
    per(4);
    chk <= 1;
    per(4);
    chk <= 0;
    de <= 0;
    per(2);
    check("oe_n", 1, oe_n);
    de <= 1;
    per(10);
    chk <= 1;
    per(4);
    chk <= 0;
    sl <= 0;
    per(2);
    check("oe_n", 1, oe_n);
    sl <= 1;
    per(12);
    chk <= 1;
    per(4);
    check("frames seen", 1, n_frames >= 30);
    summarize;
  end
endmodule // test_tbs_serializer
